// ### inc/ols_cfg.svh
// Purpose: Constants of the output list sequencer.
// Assumes: APB slave with 32-bit data, 125 MHz pclk.
// Notes: Byte addresses are word aligned.
`ifndef OLS_CFG_SVH
`define OLS_CFG_SVH

// ==========================================
// Register map
`define OLS_ADDR_MODE 8'h00
`define OLS_ADDR_REPEAT 8'h04
`define OLS_ADDR_SKIP 8'h08
`define OLS_ADDR_DIR 8'h0C
`define OLS_ADDR_CUR_APPEND 8'h10
`define OLS_ADDR_HOLD_APPEND 8'h14
`define OLS_ADDR_CUR_FILL 8'h18
`define OLS_ADDR_HOLD_FILL 8'h1C
`define OLS_ADDR_RB_START 8'h20
`define OLS_ADDR_STATUS 8'h24
`define OLS_ADDR_OUT_STATE 8'h28
`define OLS_ADDR_INST_STATE 8'h2C
`define OLS_ADDR_CLEAR 8'h30
`define OLS_WIN_CUR 2'h1
`define OLS_WIN_HOLD 2'h2

// ==========================================
// Fields and reset values
`define OLS_STAT_RUN 0
`define OLS_STAT_ERR 1
`define OLS_STAT_IDX_LO 8
`define OLS_STAT_PASS_LO 16
`define OLS_REPEAT_DEFAULT 16'h0001
`define OLS_DIR_UP 1'b1
`define OLS_TABLE_DEPTH 250
`define OLS_FILL_MAX 8'hFA
`define OLS_READ_WINDOW 16
`define OLS_MIN_HOLD 16'h0001

// ==========================================
// Timing
`define OLS_TICK_MS 10
`define OLS_CLK_MHZ 125
`define OLS_TICK_CYCLES (`OLS_TICK_MS * 1000 * `OLS_CLK_MHZ)

`endif

// ### inc/ols_pkg.sv
// Purpose: Types of the output list sequencer.
// Assumes: Nothing beyond the cfg header.
// Notes: Sequencer states are one-hot.
package ols_pkg;
   // ==========================================
   // Sequencer states
   typedef enum logic [2:0] {
      OLS_IDLE = 3'b001,
      OLS_LOAD = 3'b010,
      OLS_HOLD = 3'b100
   } ols_state_t;
   typedef logic [15:0] ols_word_t;
   typedef logic [7:0] ols_ptr_t;
endpackage

// ### verilog/ols_sequencer.sv
// Purpose: List sequencer: setpoint and hold tables, repeat and skip, APB registers.
// Assumes: Single clock pclk at 125 MHz, APB master keeps protocol.
// Notes: Answers every transfer with no wait state.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "ols_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1: Clear-list sets both table fill pointers to zero.
// R2: Clear-list restores ascending direction and repeat count one.
// R3: Repeat count 0 to 65535 sets how many times the list runs.
// R4: Repeat count zero runs forever until fixed mode is written.
// R5: Repeat count read returns the last written value.
// R6: First pass runs all steps; later passes skip the first nn steps.
// R7: Clear-list sets the skip count to zero.
// R8: Skip acts only ascending; descending runs all steps every pass.
// R9: Skip count read returns the last written value.
// R10: Current appends fill the next free setpoint location, up to 250.
// R11: A single current entry applies to every step.
// R12: Host splits long table loads over several commands.
// R13: Setpoint table read gives up to 16 values from readback start.
// R14: Current fill pointer starts at zero, counts appends, reads 0 to 250.
// R15: Ascending runs first to last; descending runs last to first.
// R16: Direction reads 1 for ascending, 0 for descending.
// R17: Hold times of 10 ms ticks, appended in order, 250 locations.
// R18: A single hold entry applies to every step.
// R19: Hold table read gives up to 16 values from readback start.
// R20: Hold fill read gives entries held, also next location, 0 to 250.
// R21: Instrument-state read behaves exactly like output-state read.
// R22: Unequal table lengths, neither one, refuse run and flag error.
// R23: Hold counted in 10 ms ticks with 16-bit count per step.
module ols_sequencer #(
   parameter int TICK_CYCLES = `OLS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Output stage
   output logic [15:0] setpoint,
   output logic output_on,
   output logic list_running,
   output logic [7:0] step_index
);

   // ==========================================
   // Storage and state
   ols_pkg::ols_word_t cur_tab [0:`OLS_TABLE_DEPTH-1];
   ols_pkg::ols_word_t hold_tab [0:`OLS_TABLE_DEPTH-1];
   ols_pkg::ols_ptr_t cur_fill;
   ols_pkg::ols_ptr_t hold_fill;
   ols_pkg::ols_word_t repeat_count;
   ols_pkg::ols_word_t first_pass_skip_count;
   logic direction_up;
   ols_pkg::ols_ptr_t readback_start_location;
   logic settings_error;
   ols_pkg::ols_state_t state;
   ols_pkg::ols_ptr_t idx;
   ols_pkg::ols_ptr_t steps;
   ols_pkg::ols_word_t passes;
   ols_pkg::ols_word_t hold_left;
   logic [20:0] tick_cnt;
   logic tick;

   // ==========================================
   // Bus decode
   logic setup;
   logic wr;
   logic wr_mode;
   logic clear_list;
   logic start_req;
   logic stop_req;
   logic mapped;
   logic run_ok;
   ols_pkg::ols_ptr_t run_len;
   logic pass_end;
   logic last_pass;
   ols_pkg::ols_ptr_t next_idx;
   ols_pkg::ols_ptr_t rb_base;
   logic [8:0] rb_loc;

   // First step of a pass; later ascending passes start past the skipped steps
   function automatic ols_pkg::ols_ptr_t first_index(input logic up, input logic later,
                                                     input ols_pkg::ols_word_t skip,
                                                     input ols_pkg::ols_ptr_t n);
      ols_pkg::ols_ptr_t r;
      r = 8'h00;
      if (!up) begin
         r = n - 8'h01; // R8 R15
      end else if (later) begin
         // A skip reaching past the end keeps only the last step
         if (skip >= {8'h00, n}) begin
            r = n - 8'h01;
         end else begin
            r = skip[7:0]; // R6
         end
      end
      return r;
   endfunction

   // Table location for a step; a single entry serves every step
   function automatic ols_pkg::ols_ptr_t table_loc(input ols_pkg::ols_ptr_t fill,
                                                   input ols_pkg::ols_ptr_t i);
      return (fill == 8'h01) ? 8'h00 : i;
   endfunction

   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign wr_mode = wr && (paddr == `OLS_ADDR_MODE);
   assign clear_list = wr && (paddr == `OLS_ADDR_CLEAR);
   assign start_req = wr_mode && pwdata[0];
   assign stop_req = wr_mode && !pwdata[0];
   assign pready = psel & penable;

   always_comb begin
      unique case (paddr)
         `OLS_ADDR_MODE, `OLS_ADDR_REPEAT, `OLS_ADDR_SKIP, `OLS_ADDR_DIR,
         `OLS_ADDR_CUR_APPEND, `OLS_ADDR_HOLD_APPEND, `OLS_ADDR_CUR_FILL,
         `OLS_ADDR_HOLD_FILL, `OLS_ADDR_RB_START, `OLS_ADDR_STATUS,
         `OLS_ADDR_OUT_STATE, `OLS_ADDR_INST_STATE, `OLS_ADDR_CLEAR: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = (paddr[7:6] == `OLS_WIN_CUR) || (paddr[7:6] == `OLS_WIN_HOLD);
         end
      endcase
   end

   assign pslverr = psel & penable & ~mapped;

   // ==========================================
   // Run checks
   always_comb begin
      run_len = (cur_fill > hold_fill) ? cur_fill : hold_fill;
      run_ok = (cur_fill != 8'h00) && (hold_fill != 8'h00) &&
               ((cur_fill == hold_fill) || (cur_fill == 8'h01) || (hold_fill == 8'h01)); // R22
   end

   always_comb begin
      pass_end = direction_up ? (idx == steps - 8'h01) : (idx == 8'h00);
      last_pass = (repeat_count != 16'h0000) && ({1'b0, passes} + 17'h00001 >= {1'b0, repeat_count}); // R3 R4
      if (direction_up) begin
         next_idx = idx + 8'h01; // R15
      end else begin
         next_idx = idx - 8'h01; // R15
      end
   end

   // ==========================================
   // Settings registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         repeat_count <= `OLS_REPEAT_DEFAULT;
         first_pass_skip_count <= 16'h0000;
         direction_up <= `OLS_DIR_UP;
         readback_start_location <= 8'h00;
      end else if (clear_list) begin
         repeat_count <= `OLS_REPEAT_DEFAULT; // R2
         first_pass_skip_count <= 16'h0000; // R7
         direction_up <= `OLS_DIR_UP; // R2
         readback_start_location <= 8'h00;
      end else if (wr) begin
         if (paddr == `OLS_ADDR_REPEAT) begin
            repeat_count <= pwdata[15:0]; // R3 R5
         end
         if (paddr == `OLS_ADDR_SKIP) begin
            first_pass_skip_count <= pwdata[15:0]; // R6 R9
         end
         if (paddr == `OLS_ADDR_DIR) begin
            direction_up <= pwdata[0]; // R16
         end
         if (paddr == `OLS_ADDR_RB_START && pwdata[7:0] <= `OLS_FILL_MAX) begin
            readback_start_location <= pwdata[7:0];
         end
      end
   end

   // ==========================================
   // Output state, shared by both state views
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_on <= 1'b0;
      end else if (wr && (paddr == `OLS_ADDR_OUT_STATE || paddr == `OLS_ADDR_INST_STATE)) begin
         output_on <= pwdata[0]; // R21
      end
   end

   // ==========================================
   // Table fill pointers and appends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_fill <= 8'h00;
      end else if (clear_list) begin
         cur_fill <= 8'h00; // R1 R14
      end else if (wr && paddr == `OLS_ADDR_CUR_APPEND && cur_fill < `OLS_FILL_MAX) begin
         cur_fill <= cur_fill + 8'h01; // R10 R14
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_fill <= 8'h00;
      end else if (clear_list) begin
         hold_fill <= 8'h00; // R1 R20
      end else if (wr && paddr == `OLS_ADDR_HOLD_APPEND && hold_fill < `OLS_FILL_MAX) begin
         hold_fill <= hold_fill + 8'h01; // R17 R20
      end
   end

   // Table memories carry no reset; fill pointers say what is valid
   always_ff @(posedge pclk) begin
      if (wr && paddr == `OLS_ADDR_CUR_APPEND && cur_fill < `OLS_FILL_MAX && !clear_list) begin
         cur_tab[cur_fill] <= pwdata[15:0]; // R10
      end
      if (wr && paddr == `OLS_ADDR_HOLD_APPEND && hold_fill < `OLS_FILL_MAX && !clear_list) begin
         // A zero hold would wrap and last 65536 ticks, so it becomes one tick
         hold_tab[hold_fill] <= (pwdata[15:0] == 16'h0000) ? `OLS_MIN_HOLD : pwdata[15:0]; // R17
      end
   end

   // ==========================================
   // Error flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settings_error <= 1'b0;
      end else if (start_req && !run_ok) begin
         settings_error <= 1'b1; // R22
      end else if (start_req || clear_list) begin
         settings_error <= 1'b0;
      end
   end

   // ==========================================
   // Tick base
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 21'h000000;
      end else if (state != ols_pkg::OLS_HOLD || tick) begin
         tick_cnt <= 21'h000000;
      end else begin
         tick_cnt <= tick_cnt + 21'h000001; // R23
      end
   end

   assign tick = (tick_cnt == 21'(TICK_CYCLES - 1));

   // ==========================================
   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ols_pkg::OLS_IDLE;
         idx <= 8'h00;
         steps <= 8'h00;
         passes <= 16'h0000;
         hold_left <= 16'h0000;
      end else if (stop_req || clear_list) begin
         state <= ols_pkg::OLS_IDLE; // R4
      end else begin
         unique case (state)
            ols_pkg::OLS_IDLE: begin
               if (start_req && run_ok) begin
                  steps <= run_len;
                  passes <= 16'h0000;
                  idx <= first_index(direction_up, 1'b0, first_pass_skip_count, run_len); // R6 R15
                  state <= ols_pkg::OLS_LOAD;
               end
            end
            ols_pkg::OLS_LOAD: begin
               hold_left <= hold_tab[table_loc(hold_fill, idx)]; // R18
               state <= ols_pkg::OLS_HOLD;
            end
            ols_pkg::OLS_HOLD: begin
               if (tick) begin
                  if (hold_left != `OLS_MIN_HOLD) begin
                     hold_left <= hold_left - 16'h0001; // R23
                  end else if (!pass_end) begin
                     idx <= next_idx; // R15
                     state <= ols_pkg::OLS_LOAD;
                  end else if (last_pass) begin
                     passes <= passes + 16'h0001; // R3
                     state <= ols_pkg::OLS_IDLE;
                  end else begin
                     passes <= passes + 16'h0001; // R4
                     idx <= first_index(direction_up, 1'b1, first_pass_skip_count, steps); // R6 R8
                     state <= ols_pkg::OLS_LOAD;
                  end
               end
            end
         endcase
      end
   end

   // Setpoint keeps the last step's value after the list ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpoint <= 16'h0000;
      end else if (state == ols_pkg::OLS_LOAD) begin
         setpoint <= cur_tab[table_loc(cur_fill, idx)]; // R11
      end
   end

   assign list_running = (state != ols_pkg::OLS_IDLE);
   assign step_index = idx;

   // ==========================================
   // Readback
   always_comb begin
      rb_base = (readback_start_location == 8'h00) ? 8'h00 : readback_start_location - 8'h01;
      rb_loc = {1'b0, rb_base} + {5'h00, paddr[5:2]}; // R13 R19
   end

   // Read data is latched in the setup phase so it is steady for the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= 32'h00000000;
         if (!pwrite) begin
            if (paddr[7:6] == `OLS_WIN_CUR) begin
               if (rb_loc < {1'b0, cur_fill}) begin
                  prdata <= {16'h0000, cur_tab[rb_loc[7:0]]}; // R13
               end
            end else if (paddr[7:6] == `OLS_WIN_HOLD) begin
               if (rb_loc < {1'b0, hold_fill}) begin
                  prdata <= {16'h0000, hold_tab[rb_loc[7:0]]}; // R19
               end
            end else begin
               unique case (paddr)
                  `OLS_ADDR_MODE: begin
                     prdata <= {31'h00000000, list_running};
                  end
                  `OLS_ADDR_REPEAT: begin
                     prdata <= {16'h0000, repeat_count}; // R5
                  end
                  `OLS_ADDR_SKIP: begin
                     prdata <= {16'h0000, first_pass_skip_count}; // R9
                  end
                  `OLS_ADDR_DIR: begin
                     prdata <= {31'h00000000, direction_up}; // R16
                  end
                  `OLS_ADDR_CUR_FILL: begin
                     prdata <= {24'h000000, cur_fill}; // R14
                  end
                  `OLS_ADDR_HOLD_FILL: begin
                     prdata <= {24'h000000, hold_fill}; // R20
                  end
                  `OLS_ADDR_RB_START: begin
                     prdata <= {24'h000000, readback_start_location};
                  end
                  `OLS_ADDR_STATUS: begin
                     prdata[`OLS_STAT_RUN] <= list_running;
                     prdata[`OLS_STAT_ERR] <= settings_error;
                     prdata[`OLS_STAT_IDX_LO +: 8] <= idx;
                     prdata[`OLS_STAT_PASS_LO +: 16] <= passes;
                  end
                  `OLS_ADDR_OUT_STATE, `OLS_ADDR_INST_STATE: begin
                     prdata <= {31'h00000000, output_on}; // R21
                  end
                  default: begin
                     prdata <= 32'h00000000;
                  end
               endcase
            end
         end
      end
   end

endmodule

`default_nettype wire

// ### verification/ols_host_model.sv
// Purpose: APB host model driving the list sequencer.
// Assumes: Zero or more wait states from the slave.
// Notes: Released address and data lines show inverted values.
`timescale 1ns/100ps
`default_nettype none
module ols_host_model (
   // Clock
   input wire logic pclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // ==========================================
   // One entry per transfer, so long table loads are split
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// ### verification/ols_seq_monitor.sv
// Purpose: Port checker for the list sequencer.
// Assumes: Bound to ols_sequencer.
// Notes: Shadow copies track the read-back registers.
`include "ols_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ols_seq_monitor #(
   parameter int TICK_CYCLES = `OLS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Output stage
   input wire logic [15:0] setpoint,
   input wire logic output_on,
   input wire logic list_running,
   input wire logic [7:0] step_index
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Shadow registers
   logic wr_acc;
   logic rd_acc;
   logic dir_m;
   logic os_m;
   logic armed;
   logic [15:0] rep_m;
   logic [15:0] skip_m;
   logic [7:0] pidx;
   logic [31:0] cnt;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_m <= `OLS_REPEAT_DEFAULT;
         skip_m <= 16'h0000;
         dir_m <= `OLS_DIR_UP;
         os_m <= 1'b0;
      end else if (wr_acc) begin
         case (paddr)
            `OLS_ADDR_REPEAT: rep_m <= pwdata[15:0];
            `OLS_ADDR_SKIP: skip_m <= pwdata[15:0];
            `OLS_ADDR_DIR: dir_m <= pwdata[0];
            `OLS_ADDR_OUT_STATE, `OLS_ADDR_INST_STATE: os_m <= pwdata[0];
            `OLS_ADDR_CLEAR: begin
               rep_m <= `OLS_REPEAT_DEFAULT;
               skip_m <= 16'h0000;
               dir_m <= `OLS_DIR_UP;
            end
            default: ;
         endcase
      end
   end
   // ==========================================
   // Step length; first change of a run is skipped, it may leave a stale index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pidx <= 8'h00;
         cnt <= 32'h00000000;
         armed <= 1'b0;
      end else begin
         pidx <= step_index;
         cnt <= (step_index != pidx) ? 32'h00000001 : cnt + 32'h00000001;
         armed <= list_running && (armed || step_index != pidx);
      end
   end
   sequence s_step_change;
      list_running && $past(list_running) && armed && step_index != $past(step_index);
   endsequence
   a_repeat_readback: assert property (rd_acc && paddr == `OLS_ADDR_REPEAT |->
      prdata == {16'h0000, rep_m}) else $error("repeat read mismatch");
   a_skip_readback: assert property (rd_acc && paddr == `OLS_ADDR_SKIP |->
      prdata == {16'h0000, skip_m}) else $error("skip read mismatch");
   a_dir_readback: assert property (rd_acc && paddr == `OLS_ADDR_DIR |->
      prdata == {31'h00000000, dir_m}) else $error("direction read mismatch");
   a_state_alias: assert property (rd_acc && paddr == `OLS_ADDR_INST_STATE |->
      prdata == {31'h00000000, os_m}) else $error("instrument state read mismatch");
   a_cur_fill_range: assert property (rd_acc && paddr == `OLS_ADDR_CUR_FILL |->
      prdata <= {24'h000000, `OLS_FILL_MAX}) else $error("current fill out of range");
   a_hold_fill_range: assert property (rd_acc && paddr == `OLS_ADDR_HOLD_FILL |->
      prdata <= {24'h000000, `OLS_FILL_MAX}) else $error("hold fill out of range");
   a_step_order: assert property (s_step_change |->
      (dir_m ? (step_index == $past(step_index) + 8'h01 || step_index < $past(step_index))
      : (step_index == $past(step_index) - 8'h01 || step_index > $past(step_index))))
      else $error("step order broken");
   a_step_dwell: assert property (s_step_change |-> cnt >= TICK_CYCLES)
      else $error("step shorter than one tick");
endmodule
bind ols_sequencer ols_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .setpoint, .output_on,
   .list_running, .step_index);
`default_nettype wire

// ### verification/ols_tb.sv
// Purpose: Self-checking bench for the list sequencer.
// Assumes: Short tick of 4 cycles, hold of one tick per step.
// Notes: Step order and setpoints come from a reference function.
`include "ols_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ==========================================
   // Wiring
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   wire logic psel, penable, pwrite, pready, pslverr, output_on, list_running;
   wire logic [7:0] paddr, step_index;
   wire logic [31:0] pwdata, prdata;
   wire logic [15:0] setpoint;
   int failures = 0;
   int num_checks = 0;
   int age = 0;
   logic [31:0] rdat;
   logic rerr;
   logic last_r = 1'b0;
   logic [7:0] last_s;
   logic [7:0] exp_q[$];
   logic [7:0] got_s[$];
   logic [15:0] got_v[$];
   logic [15:0] cur[$];
   initial begin
      forever #4 pclk = ~pclk;
   end
   ols_sequencer #(.TICK_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .setpoint, .output_on, .list_running, .step_index);
   ols_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);
   // ==========================================
   // Helpers
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rdat, rerr);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h00000000, rdat, rerr);
      chk(nm, rdat, exp);
   endtask
   function automatic void seqgen(input int n, input int rep, input int sk, input bit up);
      exp_q.delete();
      for (int p = 0; p < rep; p++) begin
         for (int k = 0; k < n; k++) begin
            if (!(up && p > 0 && k < sk)) begin
               exp_q.push_back(up ? 8'(k) : 8'(n - 1 - k));
            end
         end
      end
   endfunction
   task automatic load(input int nc, input int nh);
      wr(`OLS_ADDR_CLEAR, 32'h00000000);
      cur.delete();
      for (int i = 0; i < nc; i++) begin
         cur.push_back(16'($urandom));
         wr(`OLS_ADDR_CUR_APPEND, {16'h0000, cur[i]});
      end
      for (int i = 0; i < nh; i++) begin
         wr(`OLS_ADDR_HOLD_APPEND, 32'h00000001);
      end
   endtask
   task automatic run(input int n, input int rep, input int sk, input bit up);
      seqgen(n, rep, sk, up);
      got_s.delete();
      got_v.delete();
      wr(`OLS_ADDR_REPEAT, 32'(rep));
      wr(`OLS_ADDR_SKIP, 32'(sk));
      wr(`OLS_ADDR_DIR, {31'h00000000, up});
      wr(`OLS_ADDR_MODE, 32'h00000001);
      repeat (3) @(posedge pclk);
      wait (list_running === 1'b0);
      chk("steps", 32'(got_s.size()), 32'(exp_q.size()));
      foreach (exp_q[i]) begin
         chk("step", got_s[i], exp_q[i]);
         chk("setpoint", got_v[i], cur[cur.size() == 1 ? 0 : exp_q[i]]);
      end
   endtask
   // Samples each step once it has settled
   always @(negedge pclk) begin
      if (list_running === 1'b1) begin
         age = (last_r && step_index === last_s) ? age + 1 : 0;
         if (age == 2) begin
            got_s.push_back(step_index);
            got_v.push_back(setpoint);
         end
      end
      last_r = list_running;
      last_s = step_index;
   end
   // ==========================================
   // Tests
   initial begin
      void'($urandom(32'h6c82));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd("repeat", `OLS_ADDR_REPEAT, 32'h00000001);
      for (int i = 0; i < 4; i++) begin
         logic [15:0] v;
         v = (i == 0) ? 16'hFFFF : 16'($urandom);
         wr(`OLS_ADDR_REPEAT, {16'h0000, v});
         rd("repeat", `OLS_ADDR_REPEAT, {16'h0000, v});
         wr(`OLS_ADDR_SKIP, {16'h0000, ~v});
         rd("skip", `OLS_ADDR_SKIP, {16'h0000, ~v});
      end
      wr(`OLS_ADDR_DIR, 32'h00000000);
      rd("dir", `OLS_ADDR_DIR, 32'h00000000);
      load(3, 3);
      rd("repeat", `OLS_ADDR_REPEAT, 32'h00000001);
      rd("skip", `OLS_ADDR_SKIP, 32'h00000000);
      rd("dir", `OLS_ADDR_DIR, 32'h00000001);
      rd("cfill", `OLS_ADDR_CUR_FILL, 32'h00000003);
      rd("hfill", `OLS_ADDR_HOLD_FILL, 32'h00000003);
      rd("cwin", 8'h48, {16'h0000, cur[2]});
      rd("cwin", 8'h4C, 32'h00000000);
      rd("hwin", 8'h84, 32'h00000001);
      wr(`OLS_ADDR_RB_START, 32'h00000002);
      rd("cwin", 8'h40, {16'h0000, cur[1]});
      run(3, 2, 1, 1'b1);
      run(3, 2, 1, 1'b0);
      load(1, 3);
      run(3, 1, 0, 1'b1);
      load(3, 1);
      run(3, 1, 0, 1'b1);
      load(2, 3);
      wr(`OLS_ADDR_MODE, 32'h00000001);
      host.xfer(1'b0, `OLS_ADDR_STATUS, 32'h00000000, rdat, rerr);
      chk("status", rdat & 32'h00000003, 32'h00000002);
      load(3, 3);
      wr(`OLS_ADDR_REPEAT, 32'h00000000);
      wr(`OLS_ADDR_MODE, 32'h00000001);
      repeat (60) @(posedge pclk);
      chk("running", {31'h00000000, list_running}, 32'h00000001);
      wr(`OLS_ADDR_MODE, 32'h00000000);
      repeat (3) @(posedge pclk);
      chk("running", {31'h00000000, list_running}, 32'h00000000);
      wr(`OLS_ADDR_INST_STATE, 32'h00000001);
      rd("outstate", `OLS_ADDR_OUT_STATE, 32'h00000001);
      chk("output_on", {31'h00000000, output_on}, 32'h00000001);
      wr(`OLS_ADDR_OUT_STATE, 32'h00000000);
      rd("inststate", `OLS_ADDR_INST_STATE, 32'h00000000);
      chk("output_on", {31'h00000000, output_on}, 32'h00000000);
      for (int i = 0; i < 251; i++) begin
         wr(`OLS_ADDR_CUR_APPEND, 32'(i));
      end
      rd("cfill", `OLS_ADDR_CUR_FILL, 32'h000000FA);
      wr(`OLS_ADDR_CLEAR, 32'h00000000);
      rd("cfill", `OLS_ADDR_CUR_FILL, 32'h00000000);
      rd("hfill", `OLS_ADDR_HOLD_FILL, 32'h00000000);
      host.xfer(1'b0, 8'h34, 32'h00000000, rdat, rerr);
      chk("pslverr", {31'h00000000, rerr}, 32'h00000001);
      test_done;
   end
   initial begin
      #200000;
      failures++;
      test_done;
   end
endmodule
`default_nettype wire
